// file: src/dcpt_pkg.sv
// package: packet timing constants and command codes for the row and column packet channel
package dcpt_pkg;
  // ************************************************************
  // timing counts, in channel clock cycles
  // ************************************************************
  localparam int unsigned DCPT_WRITE_DELAY = 6;
  localparam int unsigned DCPT_COL_SPACING = 4;
  localparam int unsigned DCPT_PACKET_LEN = 4;
  localparam int unsigned DCPT_RETIRE_SPACING = 8;
  localparam int unsigned DCPT_PRE_OFFSET = 4;
  localparam int unsigned DCPT_RD_TO_PRE = 4;
  localparam int unsigned DCPT_RET_TO_PRE = 4;
  // open-row limit, absolute time
  localparam int unsigned DCPT_OPEN_LIMIT_US = 64;
  localparam int unsigned DCPT_CLK_MHZ = 100;
  localparam int unsigned DCPT_OPEN_LIMIT_CYC = DCPT_OPEN_LIMIT_US * DCPT_CLK_MHZ;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned DCPT_BANKS = 32;
  localparam int unsigned DCPT_BANK_W = 5;
  localparam int unsigned DCPT_DATA_W = 18;
  localparam int unsigned DCPT_CNT_W = 4;
  localparam int unsigned DCPT_OPEN_W = 16;
  localparam logic [DCPT_CNT_W-1:0] DCPT_CNT_ONE = 4'h1;
  localparam logic [DCPT_CNT_W-1:0] DCPT_CNT_ZERO = 4'h0;
  localparam logic [DCPT_OPEN_W-1:0] DCPT_OPEN_ZERO = 16'h0000;
  localparam logic [DCPT_OPEN_W-1:0] DCPT_OPEN_ONE = 16'h0001;
  // ************************************************************
  // column command codes
  // ************************************************************
  typedef enum logic [2:0] {
    DCPT_COL_NOP = 3'h0,
    DCPT_COL_RD = 3'h1,
    DCPT_COL_RDA = 3'h2,
    DCPT_COL_WR = 3'h3,
    DCPT_COL_WRA = 3'h4,
    DCPT_COL_RETIRE = 3'h5,
    DCPT_COL_COLUMN_PRECHARGE_CMD = 3'h6
  } dcpt_col_t;
  // row packet codes
  typedef enum logic [1:0] {
    DCPT_ROW_NOP = 2'h0,
    DCPT_ROW_ACT = 2'h1,
    DCPT_ROW_ROW_PRECHARGE_CMD = 2'h2
  } dcpt_row_t;
endpackage

// file: src/dcpt_if.sv
// interface: packet channel between controller and memory device
`timescale 1ns/1ns
`default_nettype none
interface dcpt_if;
  import dcpt_pkg::*;
  // packet starts (one-cycle pulse on the first packet cycle)
  logic row_start;
  dcpt_row_t row_cmd;
  logic [DCPT_BANK_W-1:0] row_bank;
  logic col_start;
  dcpt_col_t col_cmd;
  logic [DCPT_BANK_W-1:0] col_bank;
  logic mask_start;
  logic ext_start;
  logic ext_extended_precharge_cmd;
  logic [DCPT_BANK_W-1:0] ext_bank;
  // write data, valid for one cycle
  logic wdata_valid;
  logic [DCPT_DATA_W-1:0] wdata;
  modport ctrl (
    output row_start, row_cmd, row_bank, col_start, col_cmd, col_bank,
    output mask_start, ext_start, ext_extended_precharge_cmd, ext_bank, wdata_valid, wdata
  );
  modport dev (
    input row_start, row_cmd, row_bank, col_start, col_cmd, col_bank,
    input mask_start, ext_start, ext_extended_precharge_cmd, ext_bank, wdata_valid, wdata
  );
endinterface
`default_nettype wire

// file: src/dcpt_ctrl.sv
// controller end: issues packets only when every spacing has elapsed, except a read or retire and a same-bank row precharge issued in one cycle
`timescale 1ns/1ns
`default_nettype none
module dcpt_ctrl
  import dcpt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // user row request
  input wire logic row_req,
  input wire dcpt_pkg::dcpt_row_t row_req_cmd,
  input wire logic [dcpt_pkg::DCPT_BANK_W-1:0] row_req_bank,
  output logic row_ack,
  // user column request (mask sent with retire)
  input wire logic col_req,
  input wire dcpt_pkg::dcpt_col_t col_req_cmd,
  input wire logic [dcpt_pkg::DCPT_BANK_W-1:0] col_req_bank,
  input wire logic [dcpt_pkg::DCPT_DATA_W-1:0] col_req_wdata,
  output logic col_ack,
  // bank held open too long
  output logic open_overrun,
  // channel
  dcpt_if.ctrl ch
);
  import dcpt_pkg::*;

  // ************************************************************
  // spacing counters
  // ************************************************************
  logic [DCPT_CNT_W-1:0] col_gap_reg, row_gap_reg, retire_gap_reg;
  logic [DCPT_CNT_W-1:0] pre_gap_reg [DCPT_BANKS];
  logic [DCPT_CNT_W-1:0] wd_cnt_reg;
  logic [DCPT_DATA_W-1:0] wd_hold_reg;
  logic [DCPT_OPEN_W-1:0] open_cnt_reg [DCPT_BANKS];
  logic [DCPT_BANKS-1:0] open_reg;
  logic row_ack_reg, col_ack_reg, overrun_reg;
  logic row_start_reg, col_start_reg, mask_start_reg, wdv_reg;
  dcpt_row_t row_cmd_reg;
  dcpt_col_t col_cmd_reg;
  logic [DCPT_BANK_W-1:0] row_bank_reg, col_bank_reg;

  function automatic logic [DCPT_CNT_W-1:0] dec(input logic [DCPT_CNT_W-1:0] c);
    dec = (c == DCPT_CNT_ZERO) ? DCPT_CNT_ZERO : c - DCPT_CNT_ONE;
  endfunction

  // ************************************************************
  // issue decisions
  // ************************************************************
  wire is_retire = (col_req_cmd == DCPT_COL_RETIRE);
  wire is_write = (col_req_cmd == DCPT_COL_WR) || (col_req_cmd == DCPT_COL_WRA);
  wire is_rd = (col_req_cmd == DCPT_COL_RD) || (col_req_cmd == DCPT_COL_RDA);
  // one write data slot in flight; a second write waits for it
  wire col_ok = (col_gap_reg == DCPT_CNT_ZERO)
    && (!is_retire || retire_gap_reg == DCPT_CNT_ZERO)
    && (!is_write || wd_cnt_reg == DCPT_CNT_ZERO);
  wire col_go = col_req && col_ok && !col_ack_reg;
  wire is_pre = (row_req_cmd == DCPT_ROW_ROW_PRECHARGE_CMD);
  wire row_ok = (row_gap_reg == DCPT_CNT_ZERO)
    && (!is_pre || pre_gap_reg[row_req_bank] == DCPT_CNT_ZERO);
  wire row_go = row_req && row_ok && !row_ack_reg;
  // col precharges close the bank the same as a row precharge
  wire col_closes = col_go && (col_req_cmd == DCPT_COL_COLUMN_PRECHARGE_CMD
    || col_req_cmd == DCPT_COL_RDA || col_req_cmd == DCPT_COL_RETIRE);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      col_gap_reg <= DCPT_CNT_ZERO;
      row_gap_reg <= DCPT_CNT_ZERO;
      retire_gap_reg <= DCPT_CNT_ZERO;
      wd_cnt_reg <= DCPT_CNT_ZERO;
      wd_hold_reg <= '0;
      row_ack_reg <= 1'b0;
      col_ack_reg <= 1'b0;
      row_start_reg <= 1'b0;
      col_start_reg <= 1'b0;
      mask_start_reg <= 1'b0;
      wdv_reg <= 1'b0;
      row_cmd_reg <= DCPT_ROW_NOP;
      col_cmd_reg <= DCPT_COL_NOP;
      row_bank_reg <= '0;
      col_bank_reg <= '0;
    end
    else
    begin
      col_gap_reg <= col_go ? DCPT_CNT_W'(DCPT_COL_SPACING - 1) : dec(col_gap_reg);
      row_gap_reg <= row_go ? DCPT_CNT_W'(DCPT_PACKET_LEN - 1) : dec(row_gap_reg);
      retire_gap_reg <= (col_go && is_write) ? DCPT_CNT_W'(DCPT_RETIRE_SPACING - 1)
        : dec(retire_gap_reg);
      // write data lands exactly six cycles after the write packet
      wd_cnt_reg <= (col_go && is_write) ? DCPT_CNT_W'(DCPT_WRITE_DELAY) : dec(wd_cnt_reg);
      if (col_go && is_write)
        wd_hold_reg <= col_req_wdata;
      wdv_reg <= (wd_cnt_reg == DCPT_CNT_ONE);
      row_ack_reg <= row_go;
      col_ack_reg <= col_go;
      row_start_reg <= row_go;
      col_start_reg <= col_go;
      mask_start_reg <= col_go && is_retire;
      row_cmd_reg <= row_go ? row_req_cmd : DCPT_ROW_NOP;
      col_cmd_reg <= col_go ? col_req_cmd : DCPT_COL_NOP;
      if (row_go)
        row_bank_reg <= row_req_bank;
      if (col_go)
        col_bank_reg <= col_req_bank;
    end
  end

  // ************************************************************
  // per-bank precharge spacing and open-time watch
  // ************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      open_reg <= '0;
      overrun_reg <= 1'b0;
      for (int b = 0; b < DCPT_BANKS; b++)
      begin
        pre_gap_reg[b] <= DCPT_CNT_ZERO;
        open_cnt_reg[b] <= DCPT_OPEN_ZERO;
      end
    end
    else
    begin
      for (int b = 0; b < DCPT_BANKS; b++)
      begin
        if (col_go && col_req_bank == DCPT_BANK_W'(b) && (is_rd || is_retire))
          pre_gap_reg[b] <= DCPT_CNT_W'(DCPT_RD_TO_PRE - 1);
        else
          pre_gap_reg[b] <= dec(pre_gap_reg[b]);
        if (row_go && row_req_bank == DCPT_BANK_W'(b) && row_req_cmd == DCPT_ROW_ACT)
        begin
          open_reg[b] <= 1'b1;
          open_cnt_reg[b] <= DCPT_OPEN_ZERO;
        end
        else if ((row_go && is_pre && row_req_bank == DCPT_BANK_W'(b))
          || (col_closes && col_req_bank == DCPT_BANK_W'(b)))
          open_reg[b] <= 1'b0;
        else if (open_reg[b] && open_cnt_reg[b] != DCPT_OPEN_W'(DCPT_OPEN_LIMIT_CYC))
          open_cnt_reg[b] <= open_cnt_reg[b] + DCPT_OPEN_ONE;
      end
      overrun_reg <= 1'b0;
      for (int b = 0; b < DCPT_BANKS; b++)
        if (open_reg[b] && open_cnt_reg[b] == DCPT_OPEN_W'(DCPT_OPEN_LIMIT_CYC))
          overrun_reg <= 1'b1;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign row_ack = row_ack_reg;
  assign col_ack = col_ack_reg;
  assign open_overrun = overrun_reg;
  assign ch.row_start = row_start_reg;
  assign ch.row_cmd = row_cmd_reg;
  assign ch.row_bank = row_bank_reg;
  assign ch.col_start = col_start_reg;
  assign ch.col_cmd = col_cmd_reg;
  assign ch.col_bank = col_bank_reg;
  // extended packets not generated; column precharge covers the same case
  assign ch.ext_start = 1'b0;
  assign ch.ext_extended_precharge_cmd = 1'b0;
  assign ch.ext_bank = '0;
  assign ch.mask_start = mask_start_reg;
  assign ch.wdata_valid = wdv_reg;
  assign ch.wdata = wd_hold_reg;
endmodule
`default_nettype wire

// file: src/dcpt_dev.sv
// device end: samples write data, schedules implied precharges
`timescale 1ns/1ns
`default_nettype none
module dcpt_dev
  import dcpt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // channel
  dcpt_if.dev ch,
  // captured write data, one-cycle pulse
  output logic wr_valid,
  output logic [dcpt_pkg::DCPT_DATA_W-1:0] wr_data,
  output logic [dcpt_pkg::DCPT_BANK_W-1:0] wr_bank,
  // precharge performed, one-cycle pulse
  output logic pre_valid,
  output logic [dcpt_pkg::DCPT_BANK_W-1:0] pre_bank
);
  import dcpt_pkg::*;

  // ************************************************************
  // delay lines: one slot per cycle, since packets start 4 apart
  // ************************************************************
  logic [DCPT_WRITE_DELAY-1:0] wr_pipe_reg;
  logic [DCPT_BANK_W-1:0] wr_bank_pipe_reg [DCPT_WRITE_DELAY];
  logic [DCPT_PRE_OFFSET-1:0] pre_pipe_reg;
  logic [DCPT_BANK_W-1:0] pre_bank_pipe_reg [DCPT_PRE_OFFSET];
  logic wr_valid_reg, pre_valid_reg;
  logic [DCPT_DATA_W-1:0] wr_data_reg;
  logic [DCPT_BANK_W-1:0] wr_bank_reg, pre_bank_reg;

  wire col_wr = ch.col_start && (ch.col_cmd == DCPT_COL_WR || ch.col_cmd == DCPT_COL_WRA);
  // triggers of an implied precharge; retire assumed to follow a write with autoprecharge
  wire col_pre = ch.col_start && (ch.col_cmd == DCPT_COL_RDA
    || ch.col_cmd == DCPT_COL_RETIRE || ch.col_cmd == DCPT_COL_COLUMN_PRECHARGE_CMD);
  wire ext_pre = ch.ext_start && ch.ext_extended_precharge_cmd;
  wire pre_in = col_pre || ext_pre;
  wire [DCPT_BANK_W-1:0] pre_in_bank = col_pre ? ch.col_bank : ch.ext_bank;
  // slot 0 enters now, the oldest slot leaves after exactly the offset
  wire wr_due = wr_pipe_reg[DCPT_WRITE_DELAY-1];
  wire pre_due = pre_pipe_reg[DCPT_PRE_OFFSET-1];

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wr_pipe_reg <= '0;
      pre_pipe_reg <= '0;
      for (int i = 0; i < DCPT_WRITE_DELAY; i++)
        wr_bank_pipe_reg[i] <= '0;
      for (int i = 0; i < DCPT_PRE_OFFSET; i++)
        pre_bank_pipe_reg[i] <= '0;
      wr_valid_reg <= 1'b0;
      pre_valid_reg <= 1'b0;
      wr_data_reg <= '0;
      wr_bank_reg <= '0;
      pre_bank_reg <= '0;
    end
    else
    begin
      wr_pipe_reg <= {wr_pipe_reg[DCPT_WRITE_DELAY-2:0], col_wr};
      pre_pipe_reg <= {pre_pipe_reg[DCPT_PRE_OFFSET-2:0], pre_in};
      wr_bank_pipe_reg[0] <= ch.col_bank;
      pre_bank_pipe_reg[0] <= pre_in_bank;
      for (int i = 1; i < DCPT_WRITE_DELAY; i++)
        wr_bank_pipe_reg[i] <= wr_bank_pipe_reg[i-1];
      for (int i = 1; i < DCPT_PRE_OFFSET; i++)
        pre_bank_pipe_reg[i] <= pre_bank_pipe_reg[i-1];
      // data bus sampled at the fixed offset only; stray data ignored
      wr_valid_reg <= wr_due;
      if (wr_due)
      begin
        wr_data_reg <= ch.wdata;
        wr_bank_reg <= wr_bank_pipe_reg[DCPT_WRITE_DELAY-1];
      end
      pre_valid_reg <= pre_due;
      if (pre_due)
        pre_bank_reg <= pre_bank_pipe_reg[DCPT_PRE_OFFSET-1];
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign wr_valid = wr_valid_reg;
  assign wr_data = wr_data_reg;
  assign wr_bank = wr_bank_reg;
  assign pre_valid = pre_valid_reg;
  assign pre_bank = pre_bank_reg;
endmodule
`default_nettype wire

// file: tb/dcpt_chk.sv
// checker: channel timing assertions between the controller and device ends
`timescale 1ns/1ns
`default_nettype none
module dcpt_chk
  import dcpt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // row and column packets
  input wire logic row_start,
  input wire dcpt_pkg::dcpt_row_t row_cmd,
  input wire logic [dcpt_pkg::DCPT_BANK_W-1:0] row_bank,
  input wire logic col_start,
  input wire dcpt_pkg::dcpt_col_t col_cmd,
  input wire logic [dcpt_pkg::DCPT_BANK_W-1:0] col_bank,
  input wire logic mask_start,
  input wire logic ext_start,
  input wire logic ext_extended_precharge_cmd,
  input wire logic [dcpt_pkg::DCPT_BANK_W-1:0] ext_bank,
  // write data
  input wire logic wdata_valid,
  input wire logic [dcpt_pkg::DCPT_DATA_W-1:0] wdata
);
  import dcpt_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  wire logic wr_col = col_start && (col_cmd inside {DCPT_COL_WR, DCPT_COL_WRA});
  wire logic ret_col = col_start && (col_cmd == DCPT_COL_RETIRE);
  wire logic rd_col = col_start && (col_cmd inside {DCPT_COL_RD, DCPT_COL_RDA});
  // bank holds for the packet length, so the compare is valid over the window
  wire logic pre_hit = row_start && (row_cmd == DCPT_ROW_ROW_PRECHARGE_CMD) && (row_bank == col_bank);
  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_write;
    wr_col;
  endsequence
  sequence s_read;
    rd_col;
  endsequence
  sequence s_retire;
    ret_col;
  endsequence
  a_wdata_offset: assert property (s_write |-> ##6 wdata_valid)
    else $error("write data not six cycles after write");
  a_wdata_cause: assert property (wdata_valid |-> $past(wr_col, 6))
    else $error("write data without a write six cycles before");
  a_col_gap: assert property (col_start |=> !col_start [*3])
    else $error("column packets closer than four");
  a_row_len: assert property (row_start |=> !row_start [*3])
    else $error("row packets closer than four");
  a_cmd_idle: assert property (col_start |=> col_cmd == DCPT_COL_NOP)
    else $error("column command not idle after start");
  a_retire_gap: assert property (s_write |=> !ret_col [*7])
    else $error("retire within eight of write");
  a_mask_gap: assert property (s_write |=> !mask_start [*7])
    else $error("mask within eight of write");
  a_mask_retire: assert property (mask_start |-> ret_col)
    else $error("mask without retire");
  a_read_pre: assert property (s_read |-> !pre_hit [*4])
    else $error("row precharge too soon after read");
  a_retire_pre: assert property (s_retire |-> !pre_hit [*4])
    else $error("row precharge too soon after retire");
endmodule
`default_nettype wire

// file: tb/dcpt_tb_top.sv
// testbench: both channel ends joined, corner and random traffic
`timescale 1ns/1ns
`default_nettype none
module dcpt_tb_top;
  import dcpt_pkg::*;
  typedef struct {int at; logic [DCPT_DATA_W-1:0] d; logic [DCPT_BANK_W-1:0] b;} dcpt_exp_t;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic row_req = 1'b0;
  logic col_req = 1'b0;
  dcpt_row_t row_req_cmd = DCPT_ROW_NOP;
  dcpt_col_t col_req_cmd = DCPT_COL_NOP;
  logic [DCPT_BANK_W-1:0] row_req_bank = 5'h00;
  logic [DCPT_BANK_W-1:0] col_req_bank = 5'h00;
  logic [DCPT_DATA_W-1:0] col_req_wdata = 18'h00000;
  logic row_ack, col_ack, open_overrun, wr_valid, pre_valid;
  logic [DCPT_DATA_W-1:0] wr_data;
  logic [DCPT_BANK_W-1:0] wr_bank, pre_bank;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  integer seed = 32'h0862;
  dcpt_exp_t wq[$];
  dcpt_exp_t pq[$];
  dcpt_col_t pv[6] = '{DCPT_COL_RD, DCPT_COL_WR, DCPT_COL_RDA, DCPT_COL_WRA, DCPT_COL_COLUMN_PRECHARGE_CMD, DCPT_COL_RETIRE};
  dcpt_col_t cv[6] = '{DCPT_COL_RD, DCPT_COL_RETIRE, DCPT_COL_COLUMN_PRECHARGE_CMD, DCPT_COL_RETIRE, DCPT_COL_RD, DCPT_COL_WR};
  dcpt_col_t rv[3] = '{DCPT_COL_RD, DCPT_COL_RDA, DCPT_COL_RETIRE};
  dcpt_if ch();
  dcpt_ctrl u_dcpt_ctrl (.sys_clk, .rstn, .row_req, .row_req_cmd, .row_req_bank, .row_ack, .col_req, .col_req_cmd,
    .col_req_bank, .col_req_wdata, .col_ack, .open_overrun, .ch(ch.ctrl));
  dcpt_dev u_dcpt_dev (.sys_clk, .rstn, .ch(ch.dev), .wr_valid, .wr_data, .wr_bank, .pre_valid, .pre_bank);
  dcpt_chk u_dcpt_chk (.sys_clk, .rstn, .row_start(ch.row_start), .row_cmd(ch.row_cmd), .row_bank(ch.row_bank),
    .col_start(ch.col_start), .col_cmd(ch.col_cmd), .col_bank(ch.col_bank), .mask_start(ch.mask_start),
    .ext_start(ch.ext_start), .ext_extended_precharge_cmd(ch.ext_extended_precharge_cmd), .ext_bank(ch.ext_bank), .wdata_valid(ch.wdata_valid),
    .wdata(ch.wdata));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  // ************************************************************
  // helpers
  // ************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic int exp_gap(input dcpt_col_t p, input dcpt_col_t c);
    return (p inside {DCPT_COL_WR, DCPT_COL_WRA} && c == DCPT_COL_RETIRE) ? DCPT_RETIRE_SPACING : DCPT_COL_SPACING;
  endfunction
  // held until the negedge where ack shows, then the caller changes or drops it
  task op(input bit r, input logic [2:0] c, input logic [4:0] b, input logic [17:0] d, output int at);
    int i;
    row_req = r;
    col_req = !r;
    row_req_cmd = dcpt_row_t'(c[1:0]);
    row_req_bank = b;
    col_req_cmd = dcpt_col_t'(c);
    col_req_bank = b;
    col_req_wdata = d;
    at = -1;
    for (i = 0; i < 40 && at < 0; i++)
    begin
      @(negedge sys_clk);
      if ((r ? row_ack : col_ack) === 1'b1)
        at = cyc;
    end
    if (at < 0)
    begin
      n_mismatch++;
      $display("[ERR] %0t no ack", $time);
      close_out();
    end
    if (!r && dcpt_col_t'(c) inside {DCPT_COL_WR, DCPT_COL_WRA})
      wq.push_back('{at + DCPT_WRITE_DELAY + 1, d, b});
    if (!r && dcpt_col_t'(c) inside {DCPT_COL_RDA, DCPT_COL_RETIRE, DCPT_COL_COLUMN_PRECHARGE_CMD})
      pq.push_back('{at + DCPT_PRE_OFFSET + 1, 18'h00000, b});
  endtask
  task idle(input int n);
    row_req = 1'b0;
    col_req = 1'b0;
    repeat (n) @(negedge sys_clk);
  endtask
  // ************************************************************
  // device outputs against the schedule
  // ************************************************************
  always @(negedge sys_clk)
  begin
    if (wq.size() > 0 && wq[0].at == cyc)
    begin
      check({wr_valid, wr_bank, wr_data}, {1'b1, wq[0].b, wq[0].d});
      void'(wq.pop_front());
    end
    else if (cyc > 0)
      check(wr_valid, 1'b0);
    if (pq.size() > 0 && pq[0].at == cyc)
    begin
      check({pre_valid, pre_bank}, {1'b1, pq[0].b});
      void'(pq.pop_front());
    end
    else if (cyc > 0)
      check(pre_valid, 1'b0);
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    int a0, a1, k;
    dcpt_col_t c, p;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    for (k = 0; k < 6; k++)
    begin
      op(1'b0, pv[k], 5'(k), 18'(k * 3 + 1), a0);
      op(1'b0, cv[k], 5'(k), 18'h2A5A5, a1);
      check(a1 - a0, exp_gap(pv[k], cv[k]));
      idle(10);
    end
    $display("test column pairs done");
    for (k = 0; k < 3; k++)
    begin
      op(1'b0, rv[k], 5'h07, 18'h00000, a0);
      op(1'b1, DCPT_ROW_ROW_PRECHARGE_CMD, 5'h07, 18'h00000, a1);
      check(a1 - a0, DCPT_RD_TO_PRE);
      idle(6);
      op(1'b0, rv[k], 5'h08, 18'h00000, a0);
      op(1'b1, DCPT_ROW_ROW_PRECHARGE_CMD, 5'h09, 18'h00000, a1);
      check(a1 - a0, 1);
      idle(10);
    end
    $display("test precharge spacing done");
    op(1'b1, DCPT_ROW_ACT, 5'h02, 18'h00000, a0);
    op(1'b1, DCPT_ROW_ACT, 5'h03, 18'h00000, a1);
    check(a1 - a0, DCPT_PACKET_LEN);
    idle(1);
    for (k = 0; k < 7000 && open_overrun !== 1'b1; k++)
      @(negedge sys_clk);
    check(cyc - a0 + 2 >= DCPT_OPEN_LIMIT_CYC && cyc - a0 <= DCPT_OPEN_LIMIT_CYC + 2, 1'b1);
    op(1'b1, DCPT_ROW_ROW_PRECHARGE_CMD, 5'h02, 18'h00000, a0);
    op(1'b1, DCPT_ROW_ROW_PRECHARGE_CMD, 5'h03, 18'h00000, a1);
    idle(3);
    check(open_overrun, 1'b0);
    $display("test open limit done");
    a0 = -100;
    p = DCPT_COL_NOP;
    for (k = 0; k < 40; k++)
    begin
      c = dcpt_col_t'(3'($unsigned($random(seed)) % 6 + 1));
      op(1'b0, c, 5'($random(seed)), 18'($random(seed)), a1);
      check(a1 - a0 >= exp_gap(p, c), 1'b1);
      a0 = a1;
      p = c;
    end
    idle(12);
    check(wq.size() + pq.size(), 0);
    $display("test random traffic done");
    // a write in flight must not surface through a reset
    op(1'b0, DCPT_COL_WR, 5'h01, 18'h3FFFF, a0);
    rstn = 1'b0;
    wq.delete();
    pq.delete();
    idle(4);
    check({row_ack, col_ack, open_overrun, wr_valid, pre_valid}, 5'h00);
    rstn = 1'b1;
    idle(1);
    op(1'b0, DCPT_COL_WRA, 5'h1F, 18'h15A5A, a0);
    idle(12);
    check(wq.size() + pq.size(), 0);
    $display("test mid reset done");
    close_out();
  end
endmodule
`default_nettype wire
